// ---- hdl/phy_regs_pkg.sv ----
package phy_regs_pkg;

   // ==================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int SW_RESET_NS = 1000;
   localparam int SW_RESET_CYCLES =
      (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SOFT_RESET_NS = 100;
   localparam int SOFT_RESET_CYCLES =
      (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   // ==================================================================
   // Register addresses
   localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
   localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
   localparam logic [4:0] ADDR_ID_LOW = 5'h03;
   localparam logic [4:0] ADDR_ADVERTISE = 5'h04;
   localparam logic [4:0] ADDR_PARTNER = 5'h05;
   localparam logic [4:0] ADDR_EXPANSION = 5'h06;
   localparam logic [4:0] ADDR_NEXT_PAGE_TX = 5'h07;
   localparam logic [4:0] ADDR_RSVD_LO = 5'h08;
   localparam logic [4:0] ADDR_RSVD_HI = 5'h0f;
   localparam logic [4:0] ADDR_PHY_SUMMARY = 5'h10;
   localparam logic [4:0] ADDR_INT_CONTROL = 5'h11;
   localparam logic [4:0] ADDR_INT_STATUS = 5'h12;
   localparam logic [4:0] ADDR_PAGE_SELECT = 5'h13;
   localparam logic [4:0] ADDR_PAGED_LO = 5'h14;
   // Page 0
   localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h14;
   localparam logic [4:0] ADDR_RX_ERRORS = 5'h15;
   localparam logic [4:0] ADDR_PCS_CONFIG = 5'h16;
   localparam logic [4:0] ADDR_EXT_LAST = 5'h1d;
   localparam logic [4:0] ADDR_PHY_CONTROL_TWO = 5'h1c;
   // Page 2
   localparam logic [4:0] ADDR_LENGTH_DETECT = 5'h14;
   localparam logic [4:0] ADDR_FREQ_OFFSET = 5'h15;
   localparam logic [4:0] ADDR_CABLE_CONTROL = 5'h16;
   localparam logic [4:0] ADDR_CABLE_WINDOW = 5'h17;
   localparam logic [4:0] ADDR_CABLE_PEAK = 5'h18;
   localparam logic [4:0] ADDR_CABLE_THRESHOLD = 5'h19;
   localparam logic [4:0] ADDR_VARIANCE_CONTROL = 5'h1a;
   localparam logic [4:0] ADDR_VARIANCE_DATA = 5'h1b;
   localparam logic [4:0] ADDR_DIAG_RSVD = 5'h1c;
   localparam logic [4:0] ADDR_LINK_QUALITY_MON = 5'h1d;
   localparam logic [4:0] ADDR_LINK_QUALITY_DATA = 5'h1e;

   localparam logic [15:0] PAGE_EXTENDED = 16'h0000;
   localparam logic [15:0] PAGE_DIAG = 16'h0002;

   // ==================================================================
   // Fields and reset values
   localparam int BC_RESET_BIT = 15;
   localparam int BC_SPEED_BIT = 13;
   localparam int BC_ANEG_BIT = 12;
   localparam int PC2_SOFT_RESET_BIT = 9;
   localparam logic [15:0] ID_HIGH_VALUE = 16'h1a2b; // Arbitrary value
   localparam logic [15:0] ID_LOW_VALUE = 16'h3c4d; // Arbitrary value
   localparam logic [15:0] CABLE_WINDOW_RESET = 16'h00ff;
   localparam logic [15:0] ZERO_WORD = 16'h0000;

   // ==================================================================
   // Management frame
   localparam logic [1:0] OP_READ = 2'b10;
   localparam logic [1:0] OP_WRITE = 2'b01;
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [5:0] HEADER_LAST = 6'h0b;
   localparam logic [5:0] DATA_LAST = 6'h0f;

   typedef enum logic [2:0] {
      MD_IDLE, MD_START, MD_HEADER, MD_TURN, MD_DATA
   } mgmt_state_t;

   typedef struct packed {
      logic [4:0] phyAddr;
      logic autoNeg;
      logic speed100;
      logic spare;
   } strap_t;

   typedef struct packed {
      logic [15:0] basicStatus;
      logic [15:0] phySummary;
      logic [15:0] falseCarrier;
      logic [15:0] rxErrors;
      logic [15:0] partnerBase;
      logic [15:0] partnerNext;
      logic partnerNextSel;
      logic [15:0] lengthDetect;
      logic [15:0] cablePeak;
      logic [15:0] cableThreshold;
      logic [15:0] varianceData;
   } phy_status_t;

endpackage

// ---- hdl/phy_reset_regs.sv ----
`timescale 1ns/1ps

// Functional notes
// - Hardware reset restores defaults, relatches straps
// - Control bit 15 starts 1 us chip reset
// - Software reset restores defaults, keeps straps
// - Control-two bit 9 resets datapath only
// - Page select at 13h chooses upper page
// - Page 0 decodes extended registers 14h-1Dh
// - Page 2 decodes diagnostics, 1Ch/1Fh reserved
// - Status except 12h, identifiers read-only; control read-write
// - 05h partner page; 08h-0Fh reserved
module phy_reset_regs (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Serial management pins
   input wire logic mdc,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   // Strap inputs and latched copy
   input wire phy_regs_pkg::strap_t strapIn,
   output phy_regs_pkg::strap_t strapLatched,
   // Hardware sourced register contents
   input wire phy_regs_pkg::phy_status_t statusIn,
   // Control towards the datapath
   output logic datapathReset,
   output logic [15:0] basicControl,
   output logic [15:0] phyControlTwo,
   output logic [15:0] cableWindow,
   output logic [15:0] pageSelect
);

   // ==================================================================
   // Declarations
   phy_regs_pkg::strap_t strap_q;
   phy_regs_pkg::mgmt_state_t state_q;
   logic [15:0] regs_q [32];
   logic [15:0] diag_q [32];
   logic mdcPrev_q;
   logic [5:0] bitCnt_q;
   logic [11:0] hdr_q;
   logic [15:0] shift_q;
   logic isRead_q;
   logic mdioOut_q;
   logic mdioOe_q;
   logic swBusy_q;
   logic [phy_regs_pkg::CNT_W-1:0] swCnt_q;
   logic [phy_regs_pkg::CNT_W-1:0] softCnt_q;
   logic datapathReset_q;
   logic mdcRise;
   logic mdcFall;
   logic wrEn;
   logic [4:0] wrAddr;
   logic [15:0] wrData;
   logic [4:0] rdAddr;
   logic [15:0] rdData;
   logic swStart;
   logic softActive;
   logic softDone;
   logic pageExt;
   logic pageDiag;

   assign mdcRise = mdc && !mdcPrev_q;
   assign mdcFall = !mdc && mdcPrev_q;
   assign pageExt = regs_q[phy_regs_pkg::ADDR_PAGE_SELECT]
                    == phy_regs_pkg::PAGE_EXTENDED;
   assign pageDiag = regs_q[phy_regs_pkg::ADDR_PAGE_SELECT]
                     == phy_regs_pkg::PAGE_DIAG;

   // ==================================================================
   // Strap capture
   // Sampled on every edge while reset_n is low, so the value that
   // stands at release is the one kept; software reset never touches it.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         strap_q <= strapIn;
      end
   end

   // ==================================================================
   // Decode helpers
   function automatic logic baseWritable(input logic [4:0] a);
      baseWritable = (a == phy_regs_pkg::ADDR_BASIC_CONTROL)
         || (a == phy_regs_pkg::ADDR_ADVERTISE)
         || (a == phy_regs_pkg::ADDR_EXPANSION)
         || (a == phy_regs_pkg::ADDR_NEXT_PAGE_TX)
         || (a == phy_regs_pkg::ADDR_INT_CONTROL)
         || (a == phy_regs_pkg::ADDR_INT_STATUS)
         || (a == phy_regs_pkg::ADDR_PAGE_SELECT);
   endfunction

   function automatic logic extWritable(input logic [4:0] a);
      extWritable = (a >= phy_regs_pkg::ADDR_PCS_CONFIG)
                    && (a <= phy_regs_pkg::ADDR_EXT_LAST);
   endfunction

   function automatic logic diagWritable(input logic [4:0] a);
      diagWritable = (a == phy_regs_pkg::ADDR_FREQ_OFFSET)
         || (a == phy_regs_pkg::ADDR_CABLE_CONTROL)
         || (a == phy_regs_pkg::ADDR_CABLE_WINDOW)
         || (a == phy_regs_pkg::ADDR_VARIANCE_CONTROL)
         || (a == phy_regs_pkg::ADDR_LINK_QUALITY_MON)
         || (a == phy_regs_pkg::ADDR_LINK_QUALITY_DATA);
   endfunction

   function automatic logic [15:0] baseDefault(input int i,
                                               input phy_regs_pkg::strap_t s);
      baseDefault = phy_regs_pkg::ZERO_WORD;
      if (i == int'(phy_regs_pkg::ADDR_BASIC_CONTROL)) begin
         baseDefault[phy_regs_pkg::BC_ANEG_BIT] = s.autoNeg;
         baseDefault[phy_regs_pkg::BC_SPEED_BIT] = s.speed100;
      end
   endfunction

   function automatic logic [15:0] diagDefault(input int i);
      diagDefault = phy_regs_pkg::ZERO_WORD;
      if (i == int'(phy_regs_pkg::ADDR_CABLE_WINDOW)) begin
         diagDefault = phy_regs_pkg::CABLE_WINDOW_RESET;
      end
   endfunction

   // ==================================================================
   // Register storage
   // Hardware reset and the start of a software reset both reload
   // defaults; only the straps decide the strap-dependent bits.
   assign swStart = wrEn && !swBusy_q
                    && (wrAddr == phy_regs_pkg::ADDR_BASIC_CONTROL)
                    && wrData[phy_regs_pkg::BC_RESET_BIT];

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < 32; i++) begin
            regs_q[i] <= baseDefault(i, strapIn);
         end
      end else if (swStart) begin
         for (int i = 0; i < 32; i++) begin
            regs_q[i] <= baseDefault(i, strap_q);
         end
      end else begin
         if (softDone) begin
            regs_q[phy_regs_pkg::ADDR_PHY_CONTROL_TWO]
               [phy_regs_pkg::PC2_SOFT_RESET_BIT] <= 1'b0;
         end
         // A write after the self clear so a new request is not lost
         if (wrEn && (baseWritable(wrAddr)
                      || (pageExt && extWritable(wrAddr)))) begin
            regs_q[wrAddr] <= wrData;
            if (wrAddr == phy_regs_pkg::ADDR_BASIC_CONTROL) begin
               regs_q[wrAddr][phy_regs_pkg::BC_RESET_BIT] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n || swStart) begin
         for (int i = 0; i < 32; i++) begin
            diag_q[i] <= diagDefault(i);
         end
      end else if (wrEn && pageDiag && diagWritable(wrAddr)) begin
         diag_q[wrAddr] <= wrData;
      end
   end

   // ==================================================================
   // Full software reset timer
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         swBusy_q <= 1'b0;
         swCnt_q <= '0;
      end else if (swStart) begin
         swBusy_q <= 1'b1;
         swCnt_q <= '0;
      end else if (swBusy_q) begin
         if (swCnt_q == phy_regs_pkg::CNT_W'(
               phy_regs_pkg::SW_RESET_CYCLES - 1)) begin
            swBusy_q <= 1'b0;
         end else begin
            swCnt_q <= swCnt_q + 1'b1;
         end
      end
   end

   // ==================================================================
   // Datapath soft reset
   // Registers stay readable and writable; only the datapath is held.
   assign softActive = regs_q[phy_regs_pkg::ADDR_PHY_CONTROL_TWO]
                       [phy_regs_pkg::PC2_SOFT_RESET_BIT];
   assign softDone = softActive && (softCnt_q == phy_regs_pkg::CNT_W'(
                        phy_regs_pkg::SOFT_RESET_CYCLES - 1));

   always_ff @(posedge core_clk) begin
      if (!reset_n || !softActive || swStart) begin
         softCnt_q <= '0;
      end else if (!softDone) begin
         softCnt_q <= softCnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         datapathReset_q <= 1'b1;
      end else begin
         datapathReset_q <= swBusy_q || softActive;
      end
   end

   // ==================================================================
   // Read decode
   always_comb begin
      rdData = phy_regs_pkg::ZERO_WORD;
      unique case (rdAddr) inside
         phy_regs_pkg::ADDR_BASIC_CONTROL: begin
            rdData = regs_q[rdAddr];
            rdData[phy_regs_pkg::BC_RESET_BIT] = swBusy_q;
         end
         phy_regs_pkg::ADDR_BASIC_STATUS:
            rdData = statusIn.basicStatus;
         phy_regs_pkg::ADDR_ID_HIGH: rdData = phy_regs_pkg::ID_HIGH_VALUE;
         phy_regs_pkg::ADDR_ID_LOW: rdData = phy_regs_pkg::ID_LOW_VALUE;
         phy_regs_pkg::ADDR_PARTNER: begin
            rdData = statusIn.partnerNextSel ? statusIn.partnerNext
                                             : statusIn.partnerBase;
         end
         [phy_regs_pkg::ADDR_RSVD_LO:phy_regs_pkg::ADDR_RSVD_HI]:
            rdData = phy_regs_pkg::ZERO_WORD;
         phy_regs_pkg::ADDR_PHY_SUMMARY: rdData = statusIn.phySummary;
         [phy_regs_pkg::ADDR_PAGED_LO:5'h1f]: begin
            if (pageExt) begin
               if (rdAddr == phy_regs_pkg::ADDR_FALSE_CARRIER) begin
                  rdData = statusIn.falseCarrier;
               end else if (rdAddr == phy_regs_pkg::ADDR_RX_ERRORS) begin
                  rdData = statusIn.rxErrors;
               end else if (extWritable(rdAddr)) begin
                  rdData = regs_q[rdAddr];
               end
            end else if (pageDiag) begin
               if (rdAddr == phy_regs_pkg::ADDR_LENGTH_DETECT) begin
                  rdData = statusIn.lengthDetect;
               end else if (rdAddr == phy_regs_pkg::ADDR_CABLE_PEAK) begin
                  rdData = statusIn.cablePeak;
               end else if (rdAddr == phy_regs_pkg::ADDR_CABLE_THRESHOLD)
               begin
                  rdData = statusIn.cableThreshold;
               end else if (rdAddr == phy_regs_pkg::ADDR_VARIANCE_DATA)
               begin
                  rdData = statusIn.varianceData;
               end else if (diagWritable(rdAddr)) begin
                  rdData = diag_q[rdAddr];
               end
            end
         end
         default: begin
            if (baseWritable(rdAddr)) begin
               rdData = regs_q[rdAddr];
            end
         end
      endcase
   end

   // ==================================================================
   // Management frame engine
   // MDC is sampled as an ordinary input; input bits are taken on its
   // rising edge and read data is launched on its falling edge.
   // Frames are ignored while the chip reset runs; the host must wait.
   assign rdAddr = {hdr_q[3:0], mdioIn};
   assign wrAddr = hdr_q[4:0];
   assign wrData = {shift_q[14:0], mdioIn};
   assign wrEn = mdcRise && (state_q == phy_regs_pkg::MD_DATA)
                 && !isRead_q && (bitCnt_q == phy_regs_pkg::DATA_LAST);

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mdcPrev_q <= 1'b0;
      end else begin
         mdcPrev_q <= mdc;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n || swBusy_q) begin
         state_q <= phy_regs_pkg::MD_IDLE;
         bitCnt_q <= '0;
         hdr_q <= '0;
         shift_q <= '0;
         isRead_q <= 1'b0;
      end else if (mdcRise) begin
         unique case (state_q)
            phy_regs_pkg::MD_IDLE: begin
               if (mdioIn) begin
                  if (bitCnt_q != phy_regs_pkg::PREAMBLE_BITS) begin
                     bitCnt_q <= bitCnt_q + 1'b1;
                  end
               end else begin
                  if (bitCnt_q == phy_regs_pkg::PREAMBLE_BITS) begin
                     state_q <= phy_regs_pkg::MD_START;
                  end
                  bitCnt_q <= '0;
               end
            end
            phy_regs_pkg::MD_START: begin
               state_q <= mdioIn ? phy_regs_pkg::MD_HEADER
                                 : phy_regs_pkg::MD_IDLE;
               bitCnt_q <= '0;
            end
            phy_regs_pkg::MD_HEADER: begin
               hdr_q <= {hdr_q[10:0], mdioIn};
               bitCnt_q <= bitCnt_q + 1'b1;
               if (bitCnt_q == phy_regs_pkg::HEADER_LAST) begin
                  bitCnt_q <= '0;
                  isRead_q <= hdr_q[10:9] == phy_regs_pkg::OP_READ;
                  shift_q <= rdData;
                  if (hdr_q[8:4] == strap_q.phyAddr
                      && (hdr_q[10:9] == phy_regs_pkg::OP_READ
                          || hdr_q[10:9] == phy_regs_pkg::OP_WRITE)) begin
                     state_q <= phy_regs_pkg::MD_TURN;
                  end else begin
                     state_q <= phy_regs_pkg::MD_IDLE;
                  end
               end
            end
            phy_regs_pkg::MD_TURN: begin
               bitCnt_q <= bitCnt_q + 1'b1;
               if (bitCnt_q == 6'h01) begin
                  bitCnt_q <= '0;
                  state_q <= phy_regs_pkg::MD_DATA;
               end
            end
            phy_regs_pkg::MD_DATA: begin
               if (!isRead_q) begin
                  shift_q <= wrData;
               end
               bitCnt_q <= bitCnt_q + 1'b1;
               if (bitCnt_q == phy_regs_pkg::DATA_LAST) begin
                  bitCnt_q <= '0;
                  state_q <= phy_regs_pkg::MD_IDLE;
               end
            end
         endcase
      end else if (mdcFall && isRead_q
                   && state_q == phy_regs_pkg::MD_DATA) begin
         shift_q <= {shift_q[14:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n || swBusy_q) begin
         mdioOut_q <= 1'b0;
         mdioOe_q <= 1'b0;
      end else if (mdcFall) begin
         if (isRead_q && state_q == phy_regs_pkg::MD_TURN
             && bitCnt_q == 6'h01) begin
            mdioOut_q <= 1'b0;
            mdioOe_q <= 1'b1;
         end else if (isRead_q && state_q == phy_regs_pkg::MD_DATA) begin
            mdioOut_q <= shift_q[15];
            mdioOe_q <= 1'b1;
         end else begin
            mdioOut_q <= 1'b0;
            mdioOe_q <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Outputs
   assign mdioOut = mdioOut_q;
   assign mdioOe = mdioOe_q;
   assign strapLatched = strap_q;
   assign datapathReset = datapathReset_q;
   assign basicControl = regs_q[phy_regs_pkg::ADDR_BASIC_CONTROL];
   assign phyControlTwo = regs_q[phy_regs_pkg::ADDR_PHY_CONTROL_TWO];
   assign cableWindow = diag_q[phy_regs_pkg::ADDR_CABLE_WINDOW];
   assign pageSelect = regs_q[phy_regs_pkg::ADDR_PAGE_SELECT];

   // ==================================================================
   // Assertions
   a_swreset_length: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      $rose(swBusy_q) |-> ##199 swBusy_q ##1 !swBusy_q)
      else $error("chip reset length wrong");
   a_swreset_defaults: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      swStart |=> regs_q[phy_regs_pkg::ADDR_ADVERTISE] == 16'h0000
                  && diag_q[phy_regs_pkg::ADDR_CABLE_WINDOW] == 16'h00ff)
      else $error("defaults not restored by chip reset");
   a_strap_kept: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      swStart |=> $stable(strap_q)
                  && basicControl[12] == strap_q.autoNeg)
      else $error("strap lost on chip reset");
   a_strap_relatch: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      $rose(reset_n) |-> strap_q == $past(strapIn)
                         && pageSelect == 16'h0000)
      else $error("strap not relatched at reset");
   a_soft_hold: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      $rose(softActive) && !swBusy_q |=> datapathReset_q
         && $stable(regs_q[phy_regs_pkg::ADDR_ADVERTISE]) || wrEn)
      else $error("soft reset behaviour wrong");
   a_soft_clears: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      $rose(softActive) |-> ##[1:25] !softActive)
      else $error("soft reset never ends");
   a_diag_reserved: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      pageDiag && rdAddr == 5'h1c |-> rdData == 16'h0000)
      else $error("reserved diag address not zero");
   a_other_page: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      !pageExt && !pageDiag && rdAddr >= 5'h14 |-> rdData == 16'h0000)
      else $error("unimplemented page not zero");
   a_page_write: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      wrEn && wrAddr == 5'h13 && !swStart |=> pageSelect == $past(wrData))
      else $error("page select not stored");
   a_status_ro: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      rdAddr == 5'h01 |-> rdData == statusIn.basicStatus)
      else $error("basic status not from hardware");
   a_reset_bit_read: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      rdAddr == 5'h00 |-> rdData[15] == swBusy_q)
      else $error("reset bit readback wrong");
   a_drive_read: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      mdioOe_q |-> isRead_q || $past(isRead_q))
      else $error("pin driven outside a read");

   c_sw_reset: cover property (@(posedge core_clk)
      disable iff (!reset_n) swStart);
   c_soft_reset: cover property (@(posedge core_clk)
      disable iff (!reset_n) softDone);
   c_diag_write: cover property (@(posedge core_clk)
      disable iff (!reset_n) wrEn && pageDiag);
   c_read_drive: cover property (@(posedge core_clk)
      disable iff (!reset_n) $rose(mdioOe_q));

endmodule

// ---- sim/mgmt_station.sv ----
`timescale 1ns/1ps

// ======================================================================
// Station manager model: drives management frames, pin pulled up
module mgmt_station #(
   parameter logic [4:0] PHY_ADDR = 5'h03
) (
   // Clock
   input wire logic core_clk,
   // Management pins
   output logic mdc,
   output logic mdoOut,
   output logic mdoOe,
   input wire logic mdioWire
);
   logic [15:0] rdWord;

   initial begin
      mdc = 1'b0;
      mdoOut = 1'b1;
      mdoOe = 1'b0;
      rdWord = 16'h0000;
   end

   // Ten core cycles per mdc period gives the edge detector margin
   task automatic bitOut(input logic b, input logic oe);
      mdc <= 1'b0;
      mdoOut <= b;
      mdoOe <= oe;
      repeat (5) @(posedge core_clk);
      mdc <= 1'b1;
      rdWord <= {rdWord[14:0], mdioWire};
      repeat (5) @(posedge core_clk);
   endtask

   // Reads release the pin from the first turnaround bit onward
   task automatic frame(input logic [1:0] op, input logic [4:0] ra,
         input logic [15:0] wd);
      logic [63:0] f;
      logic wr;
      f = {32'hffffffff, 2'b01, op, PHY_ADDR, ra, 2'b10, wd};
      wr = (op == phy_regs_pkg::OP_WRITE);
      @(posedge core_clk);
      for (int i = 63; i >= 0; i--) bitOut(f[i], wr || i > 17);
      mdc <= 1'b0;
      mdoOe <= 1'b0;
   endtask
endmodule

// ---- sim/tb_phy_reset_regs.sv ----
`timescale 1ns/1ps

module tb_phy_reset_regs;
   logic core_clk, reset_n, mdc, mdoOut, mdoOe, mdioOut, mdioOe, dpReset;
   phy_regs_pkg::strap_t strapIn, strapLatched;
   phy_regs_pkg::phy_status_t stat;
   int err_total, comparisons;
   logic [15:0] bcOut, pc2Out, winOut, pageOut;
   wire mdioWire = mdioOe ? mdioOut : (mdoOe ? mdoOut : 1'b1);

   phy_reset_regs u_phy_reset_regs (.core_clk(core_clk),
      .reset_n(reset_n), .mdc(mdc), .mdioIn(mdioWire),
      .mdioOut(mdioOut), .mdioOe(mdioOe), .strapIn(strapIn),
      .strapLatched(strapLatched), .statusIn(stat),
      .datapathReset(dpReset), .basicControl(bcOut),
      .phyControlTwo(pc2Out), .cableWindow(winOut),
      .pageSelect(pageOut));
   mgmt_station u_mgmt_station (.core_clk(core_clk), .mdc(mdc),
      .mdoOut(mdoOut), .mdoOe(mdoOe), .mdioWire(mdioWire));

   // ===================================================================
   // Access tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      u_mgmt_station.frame(phy_regs_pkg::OP_WRITE, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      u_mgmt_station.frame(phy_regs_pkg::OP_READ, a, 16'h0000);
      chk(u_mgmt_station.rdWord, e);
   endtask
   task automatic conclude;
      $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ===================================================================
   // Clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (50000) @(posedge core_clk);
      err_total++;
      conclude();
   end

   // ===================================================================
   // Tests
   initial begin
      err_total = 0;
      comparisons = 0;
      reset_n = 1'b0;
      strapIn = 8'h1c;
      stat = {16'h0101, 16'h0202, 16'h0303, 16'h0404, 16'h0505,
         16'h0606, 1'b0, 16'h0808, 16'h0909, 16'h0a0a, 16'h0b0b};
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(5'h00, 16'h1000);
      wr(5'h01, 16'hffff);
      rd(5'h01, stat.basicStatus);
      wr(5'h02, 16'hffff);
      rd(5'h02, phy_regs_pkg::ID_HIGH_VALUE);
      rd(5'h03, phy_regs_pkg::ID_LOW_VALUE);
      wr(5'h10, 16'hffff);
      rd(5'h10, stat.phySummary);
      rd(5'h05, stat.partnerBase);
      stat.partnerNextSel <= 1'b1;
      rd(5'h05, stat.partnerNext);
      wr(5'h04, 16'h1234);
      for (int a = 8; a < 16; a++) begin
         wr(5'(a), 16'hffff);
         rd(5'(a), 16'h0000);
      end
      rd(5'h04, 16'h1234);
      rd(5'h14, stat.falseCarrier);
      rd(5'h15, stat.rxErrors);
      wr(5'h16, 16'h0055);
      rd(5'h16, 16'h0055);
      wr(5'h13, phy_regs_pkg::PAGE_DIAG);
      rd(5'h13, phy_regs_pkg::PAGE_DIAG);
      chk(pageOut, phy_regs_pkg::PAGE_DIAG);
      rd(5'h14, stat.lengthDetect);
      wr(5'h16, 16'h8a00);
      rd(5'h16, 16'h8a00);
      rd(5'h17, phy_regs_pkg::CABLE_WINDOW_RESET);
      chk(winOut, phy_regs_pkg::CABLE_WINDOW_RESET);
      wr(5'h17, 16'h10f0);
      rd(5'h17, 16'h10f0);
      chk(winOut, 16'h10f0);
      rd(5'h18, stat.cablePeak);
      rd(5'h19, stat.cableThreshold);
      rd(5'h1b, stat.varianceData);
      wr(5'h1c, 16'hffff);
      rd(5'h1c, 16'h0000);
      rd(5'h1f, 16'h0000);
      wr(5'h13, 16'h0001);
      rd(5'h14, 16'h0000);
      wr(5'h16, 16'hffff);
      wr(5'h13, phy_regs_pkg::PAGE_EXTENDED);
      rd(5'h16, 16'h0055);
      wr(5'h1c, 16'h0200);
      chk(dpReset, 1'b1);
      chk(pc2Out, 16'h0200);
      rd(5'h04, 16'h1234);
      chk(dpReset, 1'b0);
      chk(pc2Out, 16'h0000);
      // New straps must not be taken by the software reset
      strapIn <= 8'h1a;
      wr(5'h00, 16'h8000);
      chk(dpReset, 1'b1);
      repeat (600) @(posedge core_clk);
      chk(dpReset, 1'b0);
      chk(strapLatched, 8'h1c);
      chk(winOut, phy_regs_pkg::CABLE_WINDOW_RESET);
      rd(5'h04, 16'h0000);
      rd(5'h00, 16'h1000);
      wr(5'h04, 16'h00ff);
      reset_n <= 1'b0;
      repeat (200) @(posedge core_clk);
      reset_n <= 1'b1;
      chk(strapLatched, 8'h1a);
      chk(bcOut, 16'h2000);
      rd(5'h04, 16'h0000);
      rd(5'h00, 16'h2000);
      conclude();
   end
endmodule
